// ===== testbench/ecr_host.sv
`default_nettype none
// --
// host register access
// --
module ecr_host (
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  output var logic [7:0] reg_addr = 8'h00,
  output var logic [7:0] reg_wdata = 8'h00,
  output var logic reg_write = 1'b0,
  output var logic reg_read = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask
endmodule // ecr_host
`default_nettype wire

// ===== testbench/ecr_status_control_assertions.sv
`default_nettype none
// --
// command pulses and power-down
// --
module ecr_chk (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic divider_sync_pulse,
  input wire logic pll_reacquire_trigger,
  input wire logic bias_calibration_trigger,
  input wire logic bank_d_power_down,
  input wire logic bank_d_single_output_power_down,
  input wire logic bank_d_single_ended_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (rst);
  wire logic hit_sync = reg_write && reg_addr == 8'h3D && reg_wdata[7];
  wire logic hit_pll_reacquire_command = reg_write && reg_addr == 8'h3E && reg_wdata[7];
  wire logic hit_bias = reg_write && reg_addr == 8'h3F && reg_wdata[7];
  wire logic any_pd = bank_d_power_down || bank_d_single_output_power_down;
  sequence s_cmd(a);
    reg_write && reg_addr == a && reg_wdata[7];
  endsequence
  chk_sync_pulse: assert property (s_cmd(8'h3D) |=> divider_sync_pulse) else $error("no sync");
  chk_sync_cause: assert property (divider_sync_pulse |-> $past(hit_sync)) else $error("sync");
  chk_pll_reacquire_command_pulse: assert property (s_cmd(8'h3E) |=> pll_reacquire_trigger) else $error("no pll_reacquire_command");
  chk_pll_reacquire_command_cause: assert property (pll_reacquire_trigger |-> $past(hit_pll_reacquire_command)) else $error("pll_reacquire_command");
  chk_bias_pulse: assert property (s_cmd(8'h3F) |=> bias_calibration_trigger) else $error("no bias");
  chk_bias_cause: assert property (bias_calibration_trigger |-> $past(hit_bias)) else $error("bias");
  chk_cmd_zero: assert property (reg_read && reg_addr == 8'h3F |=> reg_rdata == 8'h00) else $error("rd");
  chk_single_hiz: assert property (any_pd |=> !bank_d_single_ended_oe) else $error("hiz");
endmodule // ecr_chk
bind ecr_status_control ecr_chk u_chk (.mclk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .divider_sync_pulse, .pll_reacquire_trigger, .bias_calibration_trigger, .bank_d_power_down,
  .bank_d_single_output_power_down, .bank_d_single_ended_oe);
`default_nettype wire

// ===== testbench/ecr_status_control_tb.sv
`default_nettype none
// --
// bench
// --
module ecr_status_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, rst = 1, we, re, div, pll, bias, qd, qdn, se, oe, pd = 0, spd = 0;
  logic [3:0] ld = 4'h0, qa, qan, qb, qbn;
  logic [1:0] qc, qcn;
  logic [7:0] ad, wd, rdat, v;
  int fails = 0, tests_run = 0;
  always #25 mclk = ~mclk;
  ecr_host h (.mclk(mclk), .reg_rdata(rdat), .reg_addr(ad), .reg_wdata(wd), .reg_write(we), .reg_read(re));
  ecr_status_control u_dut (.mclk(mclk), .rst(rst), .reg_addr(ad), .reg_wdata(wd), .reg_write(we),
    .reg_read(re), .reg_rdata(rdat), .load_start(ld[3]), .load_done_ok(ld[2]), .load_abort(ld[1]),
    .load_checksum_bad(ld[0]), .divider_sync_pulse(div), .pll_reacquire_trigger(pll),
    .bias_calibration_trigger(bias), .bank_d_power_down(pd), .bank_d_single_output_power_down(spd),
    .bank_a_clk_in(4'hA), .bank_b_clk_in(4'h5), .bank_c_clk_in(2'h1), .bank_d_clk_in(1'h1),
    .bank_a_clock_outputs(qa), .bank_a_clock_outputs_n(qan), .bank_b_clock_outputs(qb),
    .bank_b_clock_outputs_n(qbn), .bank_c_clock_outputs(qc), .bank_c_clock_outputs_n(qcn),
    .bank_d_clock_outputs(qd), .bank_d_clock_outputs_n(qdn), .bank_d_single_ended_output(se),
    .bank_d_single_ended_oe(oe));
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e)
    begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic conclude;
    $display("checks %0d fails %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic p(logic [3:0] x);
    @(posedge mclk);
    ld <= x;
    @(posedge mclk);
    ld <= 4'h0;
  endtask
  task automatic settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task automatic t_bank;
    h.rd(8'h40, v);
    chk("en rst", 8'h0F, v);
    h.wr(8'h40, 8'h00);
    settle;
    chk("a off", 8'h0F, {qa, qan});
    chk("b off", 8'h0F, {qb, qbn});
    chk("cd off", 8'h35, {qc, qcn, qd, qdn, se, oe});
    h.wr(8'h40, 8'h0F);
    settle;
    chk("a on", 8'hA5, {qa, qan});
    chk("b on", 8'h5A, {qb, qbn});
    chk("cd on", 8'h6B, {qc, qcn, qd, qdn, se, oe});
    @(posedge mclk);
    spd <= 1'b1;
    settle;
    chk("se hiz", 8'h00, {7'h0, oe});
    @(posedge mclk);
    spd <= 1'b0;
    pd <= 1'b1;
    settle;
    chk("d pd", 8'h02, {5'h0, qd, qdn, oe});
    @(posedge mclk);
    pd <= 1'b0;
  endtask
  task automatic t_cmd;
    for (int i = 0; i < 3; i++)
    begin
      h.wr(8'h3D + 8'(i), 8'h80);
      #1 chk("cmd", 8'h04 >> i, {5'h0, div, pll, bias});
      h.wr(8'h3D + 8'(i), 8'h00);
      #1 chk("cmd0", 8'h00, {5'h0, div, pll, bias});
      h.rd(8'h3D + 8'(i), v);
      chk("cmd rd", 8'h00, v);
    end
  endtask
  task automatic t_load;
    p(4'h5);
    h.rd(8'h3B, v);
    chk("idle", 8'h00, v);
    p(4'h8);
    h.rd(8'h3B, v);
    chk("act", 8'h10, v);
    p(4'h1);
    p(4'h4);
    h.rd(8'h3B, v);
    chk("done", 8'h05, v);
    p(4'h8);
    h.rd(8'h3B, v);
    chk("again", 8'h10, v);
    p(4'h6);
    h.rd(8'h3B, v);
    chk("abort", 8'h02, v);
  endtask
  task automatic t_reset;
    h.wr(8'h40, 8'h05);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    h.rd(8'h40, v);
    chk("en after rst", 8'h0F, v);
    h.rd(8'h3B, v);
    chk("status after rst", 8'h00, v);
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_bank;
    t_cmd;
    t_load;
    t_reset;
    conclude;
  end
  initial
  begin
    #100000;
    fails++;
    conclude;
  end
endmodule // ecr_status_control_tb
`default_nettype wire

// ===== verilog/ecr_bank_gate.v
`default_nettype none

// ----------------------------------------
// gates one differential bank to true low, complement high
// ----------------------------------------
module ecr_bank_gate #(
  parameter WIDTH = 4
) (
  input wire mclk,
  input wire rst,
  input wire enable,
  input wire [WIDTH-1:0] clk_in,
  output reg [WIDTH-1:0] true_out,
  output reg [WIDTH-1:0] comp_out
);

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      true_out <= {WIDTH{1'b0}};
      comp_out <= {WIDTH{1'b1}};
    end
    else if (enable)
    begin
      true_out <= clk_in;
      comp_out <= ~clk_in;
    end
    else
    begin
      true_out <= {WIDTH{1'b0}};
      comp_out <= {WIDTH{1'b1}};
    end
  end

endmodule // ecr_bank_gate

`default_nettype wire

// ===== verilog/ecr_defines.vh
`ifndef ECR_DEFINES_VH
`define ECR_DEFINES_VH

// register offsets
`define ECR_ADDR_LOAD_STATUS 8'h3B
`define ECR_ADDR_DIV_SYNC 8'h3D
`define ECR_ADDR_PLL_REACQ 8'h3E
`define ECR_ADDR_BIAS_CAL 8'h3F
`define ECR_ADDR_BANK_EN 8'h40

// load status field positions
`define ECR_BIT_LOAD_IN_PROGRESS 4
`define ECR_BIT_LOAD_COMPLETED 2
`define ECR_BIT_LOAD_ABORTED 1
`define ECR_BIT_LOAD_CHECKSUM_ERROR 0

// command bit position
`define ECR_BIT_COMMAND 7

// bank enable field positions
`define ECR_BIT_EN_A 3
`define ECR_BIT_EN_B 2
`define ECR_BIT_EN_C 1
`define ECR_BIT_EN_D 0

// reset values
`define ECR_RST_BANK_EN 4'hF
`define ECR_RST_STATUS 4'h0

// command pulse length in cycles
`define ECR_CMD_PULSE_CYCLES 1

`endif

// ===== verilog/ecr_status_control.v
`include "ecr_defines.vh"
`default_nettype none

module ecr_status_control #(
  parameter ADDR_WIDTH = 8,
  parameter DATA_WIDTH = 8
) (
  input wire mclk,
  input wire rst,
  input wire [ADDR_WIDTH-1:0] reg_addr,
  input wire [DATA_WIDTH-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [DATA_WIDTH-1:0] reg_rdata,
  input wire load_start,
  input wire load_done_ok,
  input wire load_abort,
  input wire load_checksum_bad,
  output reg divider_sync_pulse,
  output reg pll_reacquire_trigger,
  output reg bias_calibration_trigger,
  input wire bank_d_power_down,
  input wire bank_d_single_output_power_down,
  input wire [3:0] bank_a_clk_in,
  input wire [3:0] bank_b_clk_in,
  input wire [1:0] bank_c_clk_in,
  input wire bank_d_clk_in,
  output wire [3:0] bank_a_clock_outputs,
  output wire [3:0] bank_a_clock_outputs_n,
  output wire [3:0] bank_b_clock_outputs,
  output wire [3:0] bank_b_clock_outputs_n,
  output wire [1:0] bank_c_clock_outputs,
  output wire [1:0] bank_c_clock_outputs_n,
  output reg bank_d_clock_outputs,
  output reg bank_d_clock_outputs_n,
  output reg bank_d_single_ended_output,
  output reg bank_d_single_ended_oe
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  reg load_in_progress;
  reg load_completed;
  reg load_aborted;
  reg load_checksum_error;
  reg [3:0] bank_enable;
  wire bank_d_off;

  // ----------------------------------------
  // address map sized to the register bus
  // ----------------------------------------
  localparam [ADDR_WIDTH-1:0] ADDR_LOAD_STATUS = `ECR_ADDR_LOAD_STATUS;
  localparam [ADDR_WIDTH-1:0] ADDR_DIV_SYNC = `ECR_ADDR_DIV_SYNC;
  localparam [ADDR_WIDTH-1:0] ADDR_PLL_REACQ = `ECR_ADDR_PLL_REACQ;
  localparam [ADDR_WIDTH-1:0] ADDR_BIAS_CAL = `ECR_ADDR_BIAS_CAL;
  localparam [ADDR_WIDTH-1:0] ADDR_BANK_EN = `ECR_ADDR_BANK_EN;

  // ----------------------------------------
  // next-state and decode signals
  // ----------------------------------------
  wire wr_div_sync;
  wire wr_pll_reacq;
  wire wr_bias_cal;
  wire wr_bank_en;
  wire [3:0] next_bank_enable;
  wire [DATA_WIDTH-1:0] status_word;
  wire [DATA_WIDTH-1:0] enable_word;
  reg [DATA_WIDTH-1:0] next_rdata;
  reg next_load_in_progress;
  reg next_load_completed;
  reg next_load_aborted;
  reg next_load_checksum_error;
  reg next_bank_d_true;
  reg next_bank_d_comp;
  reg next_single_out;
  reg next_single_oe;

  function is_cmd_write;
    input [ADDR_WIDTH-1:0] addr;
    input [ADDR_WIDTH-1:0] target;
    input [DATA_WIDTH-1:0] data;
    begin
      is_cmd_write = (addr == target) && data[`ECR_BIT_COMMAND];
    end
  endfunction

  // one flag placed at its bit position, all other bits zero
  function [DATA_WIDTH-1:0] flag_at;
    input integer pos;
    input flag;
    begin
      flag_at = {DATA_WIDTH{1'b0}};
      flag_at[pos] = flag;
    end
  endfunction

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  assign wr_div_sync = reg_write && is_cmd_write(reg_addr, ADDR_DIV_SYNC, reg_wdata);
  assign wr_pll_reacq = reg_write && is_cmd_write(reg_addr, ADDR_PLL_REACQ, reg_wdata);
  assign wr_bias_cal = reg_write && is_cmd_write(reg_addr, ADDR_BIAS_CAL, reg_wdata);
  assign wr_bank_en = reg_write && (reg_addr == ADDR_BANK_EN);

  // reserved upper bits of the enable byte are dropped on write
  assign next_bank_enable = wr_bank_en ? reg_wdata[3:0] : bank_enable;

  assign status_word = flag_at(`ECR_BIT_LOAD_IN_PROGRESS, load_in_progress)
    | flag_at(`ECR_BIT_LOAD_COMPLETED, load_completed)
    | flag_at(`ECR_BIT_LOAD_ABORTED, load_aborted)
    | flag_at(`ECR_BIT_LOAD_CHECKSUM_ERROR, load_checksum_error);

  // reserved bits of both readable registers return zero
  assign enable_word = {{(DATA_WIDTH-4){1'b0}}, bank_enable};

  // read data changes only on a read; it holds for the host otherwise
  always @*
  begin
    next_rdata = reg_rdata;
    if (reg_read)
    begin
      case (reg_addr)
        ADDR_LOAD_STATUS:
          next_rdata = status_word;
        ADDR_BANK_EN:
          next_rdata = enable_word;
        default:
          next_rdata = {DATA_WIDTH{1'b0}};
      endcase
    end
  end

  // ----------------------------------------
  // load status flags
  // ----------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      load_in_progress <= 1'b0;
      load_completed <= 1'b0;
      load_aborted <= 1'b0;
      load_checksum_error <= 1'b0;
    end
    else
    begin
      load_in_progress <= next_load_in_progress;
      load_completed <= next_load_completed;
      load_aborted <= next_load_aborted;
      load_checksum_error <= next_load_checksum_error;
    end
  end

  // ----------------------------------------
  // load status next state
  // ----------------------------------------
  // a new attempt wins over any outcome seen in the same cycle
  always @*
  begin
    next_load_in_progress = load_in_progress;
    next_load_completed = load_completed;
    next_load_aborted = load_aborted;
    next_load_checksum_error = load_checksum_error;
    if (load_start)
    begin
      next_load_in_progress = 1'b1;
      next_load_completed = 1'b0;
      next_load_aborted = 1'b0;
      next_load_checksum_error = 1'b0;
    end
    else if (load_in_progress)
    begin
      // outcome strobes outside a load attempt are ignored
      if (load_checksum_bad)
        next_load_checksum_error = 1'b1;
      if (load_abort)
      begin
        next_load_in_progress = 1'b0;
        next_load_aborted = 1'b1;
      end
      else if (load_done_ok)
      begin
        next_load_in_progress = 1'b0;
        next_load_completed = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // registers and self-clearing commands
  // ----------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bank_enable <= `ECR_RST_BANK_EN;
      divider_sync_pulse <= 1'b0;
      pll_reacquire_trigger <= 1'b0;
      bias_calibration_trigger <= 1'b0;
      reg_rdata <= {DATA_WIDTH{1'b0}};
    end
    else
    begin
      // command outputs are one-cycle pulses; writing zero does nothing
      divider_sync_pulse <= wr_div_sync;
      pll_reacquire_trigger <= wr_pll_reacq;
      bias_calibration_trigger <= wr_bias_cal;
      bank_enable <= next_bank_enable;
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------
  // output banks
  // ----------------------------------------
  ecr_bank_gate #(.WIDTH(4)) u_bank_a (
    .mclk(mclk),
    .rst(rst),
    .enable(bank_enable[`ECR_BIT_EN_A]),
    .clk_in(bank_a_clk_in),
    .true_out(bank_a_clock_outputs),
    .comp_out(bank_a_clock_outputs_n)
  );

  ecr_bank_gate #(.WIDTH(4)) u_bank_b (
    .mclk(mclk),
    .rst(rst),
    .enable(bank_enable[`ECR_BIT_EN_B]),
    .clk_in(bank_b_clk_in),
    .true_out(bank_b_clock_outputs),
    .comp_out(bank_b_clock_outputs_n)
  );

  ecr_bank_gate #(.WIDTH(2)) u_bank_c (
    .mclk(mclk),
    .rst(rst),
    .enable(bank_enable[`ECR_BIT_EN_C]),
    .clk_in(bank_c_clk_in),
    .true_out(bank_c_clock_outputs),
    .comp_out(bank_c_clock_outputs_n)
  );

  // ----------------------------------------
  // bank D gating and single-ended pin
  // ----------------------------------------
  assign bank_d_off = bank_d_power_down || bank_d_single_output_power_down;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      bank_d_clock_outputs <= 1'b0;
      bank_d_clock_outputs_n <= 1'b1;
      bank_d_single_ended_output <= 1'b0;
      bank_d_single_ended_oe <= 1'b0;
    end
    else
    begin
      bank_d_clock_outputs <= next_bank_d_true;
      bank_d_clock_outputs_n <= next_bank_d_comp;
      bank_d_single_ended_output <= next_single_out;
      bank_d_single_ended_oe <= next_single_oe;
    end
  end

  // ----------------------------------------
  // bank D next state
  // ----------------------------------------
  // power-down of the whole bank overrides its enable
  always @*
  begin
    next_bank_d_true = 1'b0;
    next_bank_d_comp = 1'b1;
    if (bank_enable[`ECR_BIT_EN_D] && !bank_d_power_down)
    begin
      next_bank_d_true = bank_d_clk_in;
      next_bank_d_comp = ~bank_d_clk_in;
    end
  end

  // the single-ended pin floats whenever either power-down is set
  always @*
  begin
    next_single_oe = !bank_d_off;
    next_single_out = 1'b0;
    if (bank_enable[`ECR_BIT_EN_D] && next_single_oe)
      next_single_out = bank_d_clk_in;
  end

endmodule // ecr_status_control

`default_nettype wire
